// >>> core/rss_datapath.sv
// Rotate, subtract, set, swap and skip datapath with flag and working register state
`timescale 1ns/100ps
`include "rss_defs.svh"
// Operation
// RULE_01: rotate left into working register, flags kept
// RULE_02: rotate left through carry, bit7 to carry
// RULE_03: rotate right, bit0 into bit7, no flags
// RULE_04: rotate right through carry, bit0 to carry
// RULE_05: subtract with borrow: wreg minus operand minus notC
// RULE_06: memory forms write difference to memory
// RULE_07: carry clear if negative, else set
// RULE_08: plain subtract ignores incoming carry
// RULE_09: subtracts update all six arithmetic flags
// RULE_10: decrement memory, skip when zero
// RULE_11: accumulator skip forms write working register only
// RULE_12: increment memory, skip when zero
// RULE_13: skips take two cycles, flags untouched
// RULE_14: set byte writes all ones
// RULE_15: set bit forces selected bit only
// RULE_16: skip when byte or bit nonzero
// RULE_17: nibble swap to memory or register
// RULE_18: skip when memory byte zero
// RULE_19: copy byte to register, skip if zero
// RULE_20: skip when selected bit zero
// RULE_21: zero, overflow, nibble borrow definitions
// RULE_22: sequencer squashes skipped instruction effects
module rss_datapath (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  // Request from sequencer
  input  wire logic                req_valid,
  input  wire rss_pkg::rss_req_t   req,
  // Memory write-back
  output logic                     mem_we_q,
  output logic [7:0]               mem_wdata_q,
  // Sequencing
  output logic                     skip_q,
  output logic                     busy_q,
  // Architectural state
  output logic [7:0]               working_register_q,
  output rss_pkg::rss_flags_t      flags_q
);
  rss_pkg::rss_state_t  state_q;
  rss_pkg::rss_state_t  state_d;
  rss_pkg::rss_flags_t  flags_d;
  rss_pkg::rss_flags_t  sub_flags_w;
  logic [7:0]           wreg_d;
  logic [7:0]           mem_wdata_d;
  logic                 mem_we_d;
  logic                 skip_d;
  logic                 busy_d;
  logic [7:0]           operand_w;
  logic [7:0]           sub_rhs_w;
  logic [7:0]           sub_res_w;
  logic [7:0]           rot_res_w;
  logic                 rot_carry_w;
  logic                 is_brw_w;
  logic [7:0]           dec_w;
  logic [7:0]           inc_w;
  logic                 bit_w;
  logic [7:0]           bit_mask_w;
  logic                 accept_w;

  // Single-bit mask from the bit selector
  function automatic logic [7:0] rss_bit_mask(input logic [2:0] sel);
    rss_bit_mask = `RSS_BYTE_ONE << sel;
  endfunction : rss_bit_mask

  function automatic logic rss_is_zero(input logic [7:0] v);
    rss_is_zero = (v == `RSS_BYTE_ZERO);
  endfunction : rss_is_zero

  assign operand_w  = req.mem_data;
  assign sub_rhs_w  = req.use_imm ? req.imm_data : req.mem_data;
  assign is_brw_w   = (req.op == rss_pkg::RSS_OP_SUB_BR);
  assign dec_w      = req.mem_data - `RSS_BYTE_ONE;                         // see RULE_10
  assign inc_w      = req.mem_data + `RSS_BYTE_ONE;                         // see RULE_12
  assign bit_mask_w = rss_bit_mask(req.bit_sel);
  assign bit_w      = |(req.mem_data & bit_mask_w);
  // A new request is taken only in the execute state; the dummy cycle ignores it
  assign accept_w   = req_valid & (state_q == rss_pkg::RSS_ST_EXEC);       // see RULE_22

  rss_shifter u_shifter (
    .operand   (operand_w),
    .carry_in  (flags_q.carry_flag),
    .op        (req.op),
    .value     (rot_res_w),
    .carry_out (rot_carry_w)
  );

  rss_subtractor u_subtractor (
    .minuend    (working_register_q),
    .subtrahend (sub_rhs_w),
    .borrow_in  (is_brw_w & ~flags_q.carry_flag),                          // see RULE_05
    .old_zero   (flags_q.chained_zero_flag),
    .chain      (is_brw_w),
    .diff       (sub_res_w),
    .flags      (sub_flags_w)
  );

  always_comb begin
    state_d     = state_q;
    flags_d     = flags_q;
    wreg_d      = working_register_q;
    mem_wdata_d = mem_wdata_q;
    mem_we_d    = 1'b0;
    skip_d      = 1'b0;
    busy_d      = 1'b0;
    case (state_q)
      rss_pkg::RSS_ST_EXEC: begin
        if (accept_w) begin
          case (req.op)
            rss_pkg::RSS_OP_RL,
            rss_pkg::RSS_OP_RR,
            rss_pkg::RSS_OP_SWAP: begin
              if (req.to_wreg) begin
                wreg_d = rot_res_w;                                         // see RULE_01
              end else begin
                mem_we_d    = 1'b1;                                         // see RULE_03
                mem_wdata_d = rot_res_w;                                    // see RULE_17
              end
            end
            rss_pkg::RSS_OP_RL_CY,
            rss_pkg::RSS_OP_RR_CY: begin
              flags_d.carry_flag = rot_carry_w;                             // see RULE_02
              if (req.to_wreg) begin
                wreg_d = rot_res_w;                                         // see RULE_04
              end else begin
                mem_we_d    = 1'b1;
                mem_wdata_d = rot_res_w;
              end
            end
            rss_pkg::RSS_OP_SUB,
            rss_pkg::RSS_OP_SUB_BR: begin
              flags_d = sub_flags_w;                                        // see RULE_09
              if (req.to_wreg) begin
                wreg_d = sub_res_w;                                         // see RULE_08
              end else begin
                mem_we_d    = 1'b1;                                         // see RULE_06
                mem_wdata_d = sub_res_w;
              end
            end
            rss_pkg::RSS_OP_DSZ: begin
              skip_d = rss_is_zero(dec_w);                                  // see RULE_10
              if (req.to_wreg) begin
                wreg_d = dec_w;                                             // see RULE_11
              end else begin
                mem_we_d    = 1'b1;
                mem_wdata_d = dec_w;
              end
            end
            rss_pkg::RSS_OP_ISZ: begin
              skip_d = rss_is_zero(inc_w);                                  // see RULE_12
              if (req.to_wreg) begin
                wreg_d = inc_w;                                             // see RULE_11
              end else begin
                mem_we_d    = 1'b1;
                mem_wdata_d = inc_w;
              end
            end
            rss_pkg::RSS_OP_SETB: begin
              mem_we_d    = 1'b1;
              mem_wdata_d = `RSS_BYTE_ONES;                                 // see RULE_14
            end
            rss_pkg::RSS_OP_SETI: begin
              mem_we_d    = 1'b1;
              mem_wdata_d = req.mem_data | bit_mask_w;                      // see RULE_15
            end
            rss_pkg::RSS_OP_SNZB: begin
              skip_d = ~rss_is_zero(req.mem_data);                          // see RULE_16
            end
            rss_pkg::RSS_OP_SNZI: begin
              skip_d = bit_w;                                               // see RULE_16
            end
            rss_pkg::RSS_OP_SZB: begin
              skip_d = rss_is_zero(req.mem_data);                           // see RULE_18
            end
            rss_pkg::RSS_OP_SZA: begin
              wreg_d = req.mem_data;                                        // see RULE_19
              skip_d = rss_is_zero(req.mem_data);
            end
            rss_pkg::RSS_OP_SZI: begin
              skip_d = ~bit_w;                                              // see RULE_20
            end
            default: begin
              mem_we_d = 1'b0;
            end
          endcase
          if (skip_d) begin
            state_d = rss_pkg::RSS_ST_DUMMY;                                // see RULE_13
            busy_d  = 1'b1;
          end
        end
      end
      rss_pkg::RSS_ST_DUMMY: begin
        // Dummy cycle while the next instruction is fetched; flags, register and write data hold, while skip, busy and write enable clear
        state_d = rss_pkg::RSS_ST_EXEC;                                     // see RULE_13
      end
      default: begin
        state_d = rss_pkg::RSS_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q            <= rss_pkg::RSS_ST_EXEC;
      flags_q            <= `RSS_FLAGS_RESET;
      working_register_q <= `RSS_WREG_RESET;
      mem_we_q           <= 1'b0;
      mem_wdata_q        <= `RSS_BYTE_ZERO;
      skip_q             <= 1'b0;
      busy_q             <= 1'b0;
    end else if (clk_en) begin
      state_q            <= state_d;
      flags_q            <= flags_d;
      working_register_q <= wreg_d;
      mem_we_q           <= mem_we_d;
      mem_wdata_q        <= mem_wdata_d;
      skip_q             <= skip_d;
      busy_q             <= busy_d;
    end
  end
endmodule : rss_datapath

// >>> core/rss_defs.svh
// Constants for the rotate/subtract/skip datapath
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
`define RSS_BYTE_ONES    8'hFF
`define RSS_BYTE_ZERO    8'h00
`define RSS_BYTE_ONE     8'h01
`define RSS_TOP_BIT      7
`define RSS_NIB_HI_TOP   7
`define RSS_NIB_HI_BOT   4
`define RSS_NIB_LO_TOP   3
`define RSS_NIB_LO_BOT   0
`define RSS_WREG_RESET   8'h00
`define RSS_FLAGS_RESET  6'h00
`define RSS_SKIP_CYCLES  2'h2
`endif

// >>> core/rss_pkg.sv
// Types shared by the rotate/subtract/skip datapath
package rss_pkg;
  typedef enum logic [4:0] {
    RSS_OP_NOP   = 5'h00,
    RSS_OP_RL    = 5'h01,
    RSS_OP_RL_CY = 5'h02,
    RSS_OP_RR    = 5'h03,
    RSS_OP_RR_CY = 5'h04,
    RSS_OP_SUB   = 5'h05,
    RSS_OP_SUB_BR = 5'h06,
    RSS_OP_DSZ   = 5'h07,
    RSS_OP_ISZ   = 5'h08,
    RSS_OP_SETB  = 5'h09,
    RSS_OP_SETI  = 5'h0A,
    RSS_OP_SNZB  = 5'h0B,
    RSS_OP_SNZI  = 5'h0C,
    RSS_OP_SWAP  = 5'h0D,
    RSS_OP_SZB   = 5'h0E,
    RSS_OP_SZA   = 5'h0F,
    RSS_OP_SZI   = 5'h10
  } rss_op_t;

  typedef struct packed {
    rss_op_t    op;
    logic       to_wreg;
    logic       use_imm;
    logic [2:0] bit_sel;
    logic [7:0] mem_data;
    logic [7:0] imm_data;
  } rss_req_t;

  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
    logic signed_compare_flag;
    logic chained_zero_flag;
  } rss_flags_t;

  typedef struct packed {
    logic [7:0] value;
    logic       carry_out;
    rss_flags_t sub_flags;
  } rss_alu_res_t;

  typedef enum logic [1:0] {
    RSS_ST_EXEC  = 2'b01,
    RSS_ST_DUMMY = 2'b10
  } rss_state_t;
endpackage : rss_pkg

// >>> core/rss_shifter.sv
// Rotate and nibble-swap unit
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_shifter (
  // Operand
  input  wire logic [7:0]          operand,
  input  wire logic                carry_in,
  input  wire rss_pkg::rss_op_t    op,
  // Result
  output logic [7:0]               value,
  output logic                     carry_out
);
  always_comb begin
    value     = operand;
    carry_out = carry_in;
    case (op)
      rss_pkg::RSS_OP_RL: begin
        value = {operand[6:0], operand[`RSS_TOP_BIT]};                    // see RULE_01
      end
      rss_pkg::RSS_OP_RL_CY: begin
        value     = {operand[6:0], carry_in};                             // see RULE_02
        carry_out = operand[`RSS_TOP_BIT];
      end
      rss_pkg::RSS_OP_RR: begin
        value = {operand[0], operand[7:1]};                               // see RULE_03
      end
      rss_pkg::RSS_OP_RR_CY: begin
        value     = {carry_in, operand[7:1]};                             // see RULE_04
        carry_out = operand[0];
      end
      rss_pkg::RSS_OP_SWAP: begin
        value = {operand[`RSS_NIB_LO_TOP:`RSS_NIB_LO_BOT],
                 operand[`RSS_NIB_HI_TOP:`RSS_NIB_HI_BOT]};               // see RULE_17
      end
      default: begin
        value     = operand;
        carry_out = carry_in;
      end
    endcase
  end
endmodule : rss_shifter

// >>> core/rss_subtractor.sv
// Eight-bit subtractor with borrow in and full flag set
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_subtractor (
  // Operands
  input  wire logic [7:0]          minuend,
  input  wire logic [7:0]          subtrahend,
  input  wire logic                borrow_in,
  input  wire logic                old_zero,
  input  wire logic                chain,
  // Result
  output logic [7:0]               diff,
  output rss_pkg::rss_flags_t      flags
);
  logic [8:0] full_w;
  logic [4:0] low_w;
  logic       ovf_w;

  assign full_w = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign low_w  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
  assign diff   = full_w[7:0];
  assign ovf_w  = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_w[7]);

  always_comb begin
    flags.signed_range_flag   = ovf_w;                                    // see RULE_21
    flags.zero_flag           = (full_w[7:0] == `RSS_BYTE_ZERO);          // see RULE_21
    flags.nibble_carry_flag   = ~low_w[4];                                // see RULE_21
    flags.carry_flag          = ~full_w[8];                               // see RULE_07
    flags.signed_compare_flag = ovf_w ^ full_w[7];
    flags.chained_zero_flag   = (full_w[7:0] == `RSS_BYTE_ZERO) & (~chain | old_zero);
  end
endmodule : rss_subtractor

// >>> dv/rss_datapath_sva.sv
// Port checks for the datapath
`timescale 1ns/100ps
module rss_datapath_chk (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_b,
  input wire logic                clk_en,
  // Request
  input wire logic                req_valid,
  input wire rss_pkg::rss_req_t   req,
  // Results
  input wire logic                mem_we_q,
  input wire logic [7:0]          mem_wdata_q,
  input wire logic                skip_q,
  input wire logic                busy_q,
  input wire logic [7:0]          working_register_q,
  input wire rss_pkg::rss_flags_t flags_q
);
  logic       tk;
  logic [7:0] md;
  logic [7:0] src;
  logic [7:0] rl_v;
  logic [7:0] sw_v;
  logic       hit;
  logic       mz;
  logic       top;
  logic       bot;
  assign md   = req.mem_data;
  assign src  = req.use_imm ? req.imm_data : md;
  assign rl_v = {md[6:0], md[7]};
  assign sw_v = {md[3:0], md[7:4]};
  assign hit  = md[req.bit_sel];
  assign mz   = md == 8'h00;
  assign top  = md[7];
  assign bot  = md[0];
  assign tk   = clk_en & req_valid & ~busy_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_rl_wreg_only: assert property (
    tk && req.op == rss_pkg::RSS_OP_RL && req.to_wreg |=>
      !mem_we_q && working_register_q == $past(rl_v) && $stable(flags_q)) else $error("rotate left wrong");
  a_rol_cy_out: assert property (
    tk && req.op == rss_pkg::RSS_OP_RL_CY |=> flags_q.carry_flag == $past(top))
    else $error("rotate left carry wrong");
  a_ror_cy_out: assert property (
    tk && req.op == rss_pkg::RSS_OP_RR_CY |=> flags_q.carry_flag == $past(bot))
    else $error("rotate right carry wrong");
  a_swap_to_mem: assert property (
    tk && req.op == rss_pkg::RSS_OP_SWAP && !req.to_wreg |=> mem_we_q && mem_wdata_q == $past(sw_v))
    else $error("swap wrong");
  a_set_all_ones: assert property (
    tk && req.op == rss_pkg::RSS_OP_SETB |=> mem_we_q && mem_wdata_q == 8'hFF && $stable(flags_q))
    else $error("set byte wrong");
  a_sub_carry_sense: assert property (
    tk && req.op == rss_pkg::RSS_OP_SUB |=> flags_q.carry_flag == ($past(working_register_q) >= $past(src)))
    else $error("subtract carry wrong");
  a_sz_byte_hit: assert property (
    tk && req.op == rss_pkg::RSS_OP_SZB |=> skip_q == $past(mz)) else $error("skip on zero wrong");
  a_snz_bit_hit: assert property (
    tk && req.op == rss_pkg::RSS_OP_SNZI |=> skip_q == $past(hit)) else $error("skip on bit wrong");
  a_skip_dummy_slot: assert property (
    skip_q && clk_en |-> busy_q ##1 (!skip_q && !busy_q)) else $error("dummy slot wrong");
endmodule : rss_datapath_chk

bind rss_datapath rss_datapath_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
  .req_valid(req_valid), .req(req), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .skip_q(skip_q),
  .busy_q(busy_q), .working_register_q(working_register_q), .flags_q(flags_q));

// >>> dv/rss_datapath_tb.sv
// Self-checking bench for the datapath
`timescale 1ns/100ps
module rss_datapath_tb;
  logic                ref_clk;
  logic                rst_b;
  logic                clk_en;
  logic                cmd_valid;
  rss_pkg::rss_req_t   cmd;
  logic                req_valid;
  rss_pkg::rss_req_t   req;
  logic                mem_we_q;
  logic [7:0]          mem_wdata_q;
  logic                skip_q;
  logic                busy_q;
  logic [7:0]          working_register_q;
  rss_pkg::rss_flags_t flags_q;
  logic                e_we;
  logic                e_skip;
  logic [7:0]          e_wd;
  logic [7:0]          e_wreg;
  rss_pkg::rss_flags_t e_fl;
  logic [31:0]         seed;
  int                  err_total;
  int                  n_tests;

  rss_datapath u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .skip_q(skip_q), .busy_q(busy_q),
    .working_register_q(working_register_q), .flags_q(flags_q));
  rss_seq_model u_seq (.cmd_valid(cmd_valid), .cmd(cmd), .busy_q(busy_q), .req_valid(req_valid), .req(req));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  function automatic rss_pkg::rss_req_t mk(rss_pkg::rss_op_t o, logic [7:0] m, logic tw);
    return '{o, tw, 1'b0, 3'h5, m, 8'h01};
  endfunction : mk

  // Expected outputs one edge after a slot; a frozen edge changes nothing
  function automatic void predict(rss_pkg::rss_req_t r, logic en);
    logic [7:0] m;
    logic [7:0] s;
    logic [7:0] v;
    logic [8:0] d;
    logic [4:0] n;
    logic       b;
    logic       c;
    logic       vf;
    logic       z;
    logic       tw;
    if (!en) return;
    e_we = 1'b0;
    if (e_skip) begin
      e_skip = 1'b0;
      return;
    end
    m = r.mem_data;
    c = e_fl.carry_flag;
    s = r.use_imm ? r.imm_data : m;
    b = (r.op == rss_pkg::RSS_OP_SUB_BR) ? ~c : 1'b0;
    d = {1'b0, e_wreg} - {1'b0, s} - 9'(b);
    n = {1'b0, e_wreg[3:0]} - {1'b0, s[3:0]} - 5'(b);
    z = d[7:0] == 8'h00;
    vf = (e_wreg[7] ^ s[7]) & (d[7] ^ e_wreg[7]);
    case (r.op)
      rss_pkg::RSS_OP_RL:   v = {m[6:0], m[7]};
      rss_pkg::RSS_OP_RL_CY: v = {m[6:0], c};
      rss_pkg::RSS_OP_RR:   v = {m[0], m[7:1]};
      rss_pkg::RSS_OP_RR_CY: v = {c, m[7:1]};
      rss_pkg::RSS_OP_SUB:  v = d[7:0];
      rss_pkg::RSS_OP_SUB_BR: v = d[7:0];
      rss_pkg::RSS_OP_DSZ:  v = m - 8'h01;
      rss_pkg::RSS_OP_ISZ:  v = m + 8'h01;
      rss_pkg::RSS_OP_SETB: v = 8'hFF;
      rss_pkg::RSS_OP_SETI: v = m | (8'h01 << r.bit_sel);
      rss_pkg::RSS_OP_SWAP: v = {m[3:0], m[7:4]};
      default:              v = m;
    endcase
    if (r.op == rss_pkg::RSS_OP_RL_CY) e_fl.carry_flag = m[7];
    if (r.op == rss_pkg::RSS_OP_RR_CY) e_fl.carry_flag = m[0];
    if (r.op inside {rss_pkg::RSS_OP_SUB, rss_pkg::RSS_OP_SUB_BR})
      e_fl = {vf, z, ~n[4], ~d[8], vf ^ d[7], z & (r.op == rss_pkg::RSS_OP_SUB | e_fl.chained_zero_flag)};
    e_skip = (r.op inside {rss_pkg::RSS_OP_DSZ, rss_pkg::RSS_OP_ISZ, rss_pkg::RSS_OP_SZB, rss_pkg::RSS_OP_SZA}
      && v == 8'h00) || (r.op == rss_pkg::RSS_OP_SNZB && m != 8'h00)
      || (r.op == rss_pkg::RSS_OP_SNZI && m[r.bit_sel]) || (r.op == rss_pkg::RSS_OP_SZI && !m[r.bit_sel]);
    tw = (r.to_wreg || r.op == rss_pkg::RSS_OP_SZA) && !(r.op inside {rss_pkg::RSS_OP_SETB, rss_pkg::RSS_OP_SETI});
    if (r.op inside {rss_pkg::RSS_OP_NOP, rss_pkg::RSS_OP_SNZB, rss_pkg::RSS_OP_SNZI, rss_pkg::RSS_OP_SZB,
      rss_pkg::RSS_OP_SZI}) return;
    if (tw) e_wreg = v;
    else {e_we, e_wd} = {1'b1, v};
  endfunction : predict

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Drive one slot and check the outcome of the one before
  task automatic go(rss_pkg::rss_req_t r, logic en);
    @(posedge ref_clk);
    cmd <= r;
    clk_en <= en;
    cmd_valid <= 1'b1;
    #1;
    chk("mem_we", 8'(mem_we_q), 8'(e_we));
    chk("mem_wdata", mem_wdata_q, e_wd);
    chk("skip", 8'(skip_q), 8'(e_skip));
    chk("busy", 8'(busy_q), 8'(e_skip));
    chk("wreg", working_register_q, e_wreg);
    chk("flags", 8'(flags_q), 8'(e_fl));
    predict(r, en);
  endtask : go

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    rss_pkg::rss_req_t r;
    {rst_b, clk_en, cmd_valid, cmd, seed} = {3'b010, 26'h000_0000, 32'h0001_738B};
    {e_we, e_skip, e_wd, e_wreg, e_fl, err_total, n_tests} = '0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    go(mk(rss_pkg::RSS_OP_SZB, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SETB, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_DSZ, 8'h01, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SETI, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_ISZ, 8'hFF, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_SZA, 8'h00, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_SZA, 8'h00, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_NOP, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SUB, 8'h01, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_SUB_BR, 8'h80, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SWAP, 8'h3C, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_RR_CY, 8'h81, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_RL_CY, 8'h7E, 1'b1), 1'b1);
    go(mk(rss_pkg::RSS_OP_SZI, 8'h20, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SNZI, 8'h20, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SETB, 8'h00, 1'b0), 1'b0);
    go(mk(rss_pkg::RSS_OP_NOP, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SETB, 8'h00, 1'b0), 1'b1);
    go(mk(rss_pkg::RSS_OP_SETI, 8'h00, 1'b0), 1'b1);
    $display("corner test done");
    repeat (3000) begin
      r.op = rss_pkg::rss_op_t'(5'(rnd() % 8'd17));
      {r.to_wreg, r.use_imm, r.bit_sel} = 5'(rnd());
      r.mem_data = rnd();
      r.imm_data = rnd();
      go(r, rnd() > 8'h1F);
    end
    go(mk(rss_pkg::RSS_OP_NOP, 8'h00, 1'b0), 1'b1);
    $display("random test done");
    give_verdict();
  end
endmodule : rss_datapath_tb

// >>> dv/rss_seq_model.sv
// Sequencer model feeding the datapath
`timescale 1ns/100ps
module rss_seq_model (
  // Command from bench
  input  wire logic              cmd_valid,
  input  wire rss_pkg::rss_req_t cmd,
  // Datapath side
  input  wire logic              busy_q,
  output logic                   req_valid,
  output rss_pkg::rss_req_t      req
);
  // The slot after a skip is squashed, so it leaves no trace
  assign req_valid = cmd_valid & ~busy_q;
  assign req       = cmd;
endmodule : rss_seq_model
